// [core/ep_event_irq.sv]
// sticky event status, enable mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_cfg.svh"

module ep_event_irq
  import usb_ep_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic [3:0] events,
  input  wire logic       clear_we,
  input  wire logic       enable_we,
  input  wire logic [3:0] wdata,
  output logic      [3:0] status,
  output logic      [3:0] enable,
  output logic            irq
);

  // new events win over a clear landing in the same cycle
  wire logic [3:0] status_next = (status & ~(clear_we ? wdata : 4'h0)) | events;
  wire logic [3:0] enable_next = enable_we ? wdata : enable;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status <= `IRQ_RESET;
      enable <= `IRQ_RESET;
      irq    <= 1'b0;
    end
    else
    begin
      status <= status_next;
      enable <= enable_next;
      irq    <= |(status_next & enable_next);
    end
  end

endmodule

`default_nettype wire

// [core/ep_token_filter.sv]
// registered token admission for the selected endpoint
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_cfg.svh"

module ep_token_filter
  import usb_ep_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       tok_valid,
  input  wire pid_kind_t  tok_kind,
  input  wire logic [7:0] ctrl,
  output tok_res_t        result,
  output logic            refused,
  output logic            setup_refused
);

  // decode of the token against the endpoint byte
  wire logic admit      = ep_admits(ctrl, tok_kind);
  wire logic both_dirs  = ctrl[`BIT_RX_EN] && ctrl[`BIT_TX_EN];
  wire logic setup_shut = (tok_kind == pid_setup) && both_dirs && ctrl[`BIT_CTRL_DIS];

  // one cycle of result per token; no data moves unless accept is set
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      result        <= '0;
      refused       <= 1'b0;
      setup_refused <= 1'b0;
    end
    else
    begin
      result.valid     <= tok_valid;
      result.accept    <= tok_valid && admit;                      // [RQ5] [RQ6] [RQ11]
      result.handshake <= tok_valid && admit && ctrl[`BIT_HSHK_EN]; // [RQ8]
      result.stall     <= tok_valid && admit && ctrl[`BIT_STALLED];
      refused          <= tok_valid && !admit;                     // [RQ11]
      setup_refused    <= tok_valid && setup_shut;                 // [RQ4]
    end
  end

endmodule

`default_nettype wire

// [core/usb_endpoint_control.sv]
// per-endpoint control registers and token admission for two usb modules
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_cfg.svh"

module usb_endpoint_control
  import usb_ep_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  // token from the serial engine
  input  wire logic        tok_valid,
  input  wire logic        tok_usb,
  input  wire logic [3:0]  tok_ep,
  input  wire pid_kind_t   tok_kind,
  output tok_res_t         tok_result,
  // stall report from the serial engine
  input  wire logic        stall_valid,
  input  wire logic        stall_usb,
  input  wire logic [3:0]  stall_ep,
  // NAK seen on endpoint 0 in host mode
  input  wire logic        nak_valid,
  input  wire logic        nak_usb,
  // host mode endpoint 0 controls, one bit per usb module
  output logic      [1:0]  low_speed_direct,
  output logic      [1:0]  pre_required,
  output logic      [1:0]  nak_retry,
  // level interrupt
  output logic             irq
);

  localparam int EP_TOTAL = 32;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------

  // endpoint window is the lower half: addr[6] picks the module, addr[5:2] the endpoint
  wire logic       in_ep_win  = (bus_addr[7] == 1'b0) && (bus_addr[1:0] == 2'h0);
  wire logic [4:0] ep_index   = bus_addr[6:2];
  wire logic       ep_wr      = bus_wr && in_ep_win;
  wire logic       hit_status = (bus_addr == `OFS_IRQ_STATUS);
  wire logic       hit_clear  = (bus_addr == `OFS_IRQ_CLEAR);
  wire logic       hit_enable = (bus_addr == `OFS_IRQ_ENABLE);
  wire logic       hit_host   = (bus_addr == `OFS_HOST_MODE);

  wire logic       clear_we   = bus_wr && hit_clear;
  wire logic       enable_we  = bus_wr && hit_enable;
  wire logic       host_we    = bus_wr && hit_host;

  // ----------------------------------------------------------------
  // endpoint control storage
  // ----------------------------------------------------------------

  // index 0..15 is usb module one, 16..31 is usb module two
  logic [7:0] ctrl_reg  [0:EP_TOTAL-1];                              // [RQ1]
  logic [7:0] ctrl_next [0:EP_TOTAL-1];

  wire logic [4:0] stall_index = {stall_usb, stall_ep};

  // next value per endpoint: software write, then hardware stall report on top
  genvar gi;
  generate
    for (gi = 0; gi < EP_TOTAL; gi++)
    begin : g_ep
      wire logic       wr_hit    = ep_wr && (ep_index == 5'(gi));
      wire logic       stall_hit = stall_valid && (stall_index == 5'(gi));
      // unimplemented bits never take a write, so they read zero
      wire logic [7:0] written   = wr_hit ? (bus_wdata[7:0] & `EP_CTRL_WMASK) : ctrl_reg[gi]; // [RQ9]
      // a stall in the same cycle as a software clear still sticks
      assign ctrl_next[gi] = written | (stall_hit ? 8'h02 : 8'h00);   // [RQ7]

      always_ff @(posedge mclk or negedge arst_n)
      begin
        if (!arst_n)
          ctrl_reg[gi] <= `EP_CTRL_RESET;                            // [RQ10]
        else
          ctrl_reg[gi] <= ctrl_next[gi];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // host mode register
  // ----------------------------------------------------------------

  // bit 0 puts usb module one in host mode, bit 1 module two
  logic [1:0] host_mode_reg;
  wire  logic [1:0] host_mode_next = host_we ? bus_wdata[1:0] : host_mode_reg;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      host_mode_reg <= `HOST_MODE_RESET;
    else
      host_mode_reg <= host_mode_next;
  end

  // ----------------------------------------------------------------
  // token admission
  // ----------------------------------------------------------------

  // endpoint byte looked up the same cycle the token arrives
  wire logic [4:0] tok_index = {tok_usb, tok_ep};
  wire logic [7:0] tok_ctrl  = ctrl_reg[tok_index];
  logic            tok_refused;
  logic            tok_setup_refused;

  ep_token_filter u_filter (
    .mclk          (mclk),
    .arst_n        (arst_n),
    .tok_valid     (tok_valid),
    .tok_kind      (tok_kind),
    .ctrl          (tok_ctrl),
    .result        (tok_result),
    .refused       (tok_refused),
    .setup_refused (tok_setup_refused)
  );

  // ----------------------------------------------------------------
  // endpoint 0 host controls
  // ----------------------------------------------------------------

  // only endpoint 0 of each module carries the host-mode bits
  wire logic [7:0] ep0_one = ctrl_reg[0];
  wire logic [7:0] ep0_two = ctrl_reg[16];

  wire logic [1:0] low_speed_next;
  wire logic [1:0] pre_next;
  wire logic [1:0] retry_next;

  // direct low-speed link, else a hub and a PRE token in front of low-speed traffic
  assign low_speed_next[0] = host_mode_reg[0] && ep0_one[`BIT_LOW_SPEED];  // [RQ2]
  assign low_speed_next[1] = host_mode_reg[1] && ep0_two[`BIT_LOW_SPEED];  // [RQ2]
  assign pre_next[0]       = host_mode_reg[0] && !ep0_one[`BIT_LOW_SPEED]; // [RQ2]
  assign pre_next[1]       = host_mode_reg[1] && !ep0_two[`BIT_LOW_SPEED]; // [RQ2]

  // retry request pulse after a NAK unless software turned retry off
  assign retry_next[0] = nak_valid && !nak_usb && host_mode_reg[0]
                         && !ep0_one[`BIT_RETRY_DIS];                     // [RQ3]
  assign retry_next[1] = nak_valid && nak_usb && host_mode_reg[1]
                         && !ep0_two[`BIT_RETRY_DIS];                     // [RQ3]

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_speed_direct <= 2'h0;
      pre_required     <= 2'h0;
      nak_retry        <= 2'h0;
    end
    else
    begin
      low_speed_direct <= low_speed_next;
      pre_required     <= pre_next;
      nak_retry        <= retry_next;
    end
  end

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------

  // events are one-cycle pulses; the sticky copy lives in the irq block
  wire logic [3:0] events;
  logic      [3:0] irq_status;
  logic      [3:0] irq_enable;

  assign events[`EV_STALL]         = stall_valid;
  assign events[`EV_REFUSED]       = tok_refused;
  assign events[`EV_SETUP_REFUSED] = tok_setup_refused;
  assign events[`EV_NAK_RETRY]     = |nak_retry;

  ep_event_irq u_irq (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .events    (events),
    .clear_we  (clear_we),
    .enable_we (enable_we),
    .wdata     (bus_wdata[3:0]),
    .status    (irq_status),
    .enable    (irq_enable),
    .irq       (irq)
  );

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------

  // clear register is write-only and unmapped addresses read zero
  wire logic [31:0] rd_ep     = {24'h000000, ctrl_reg[ep_index]};          // [RQ9]
  wire logic [31:0] rd_status = {28'h0000000, irq_status};
  wire logic [31:0] rd_enable = {28'h0000000, irq_enable};
  wire logic [31:0] rd_host   = {30'h00000000, host_mode_reg};
  wire logic [31:0] rd_value  = in_ep_win  ? rd_ep     :
                                hit_status ? rd_status :
                                hit_enable ? rd_enable :
                                hit_host   ? rd_host   : 32'h00000000;

  // read data stand for the single cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      bus_rdata <= 32'h00000000;
    else
      bus_rdata <= bus_rd ? rd_value : 32'h00000000;
  end

endmodule

`default_nettype wire

// [core/usb_ep_cfg.svh]
// constants for the usb endpoint control block: offsets, field positions, reset values
//
// Behaviour
// RQ1 - Each of the two usb modules has sixteen endpoint control registers, one per endpoint 0 to 15.
// RQ2 - On endpoint 0 in host mode, bit 7 set talks straight to a low-speed device, clear needs a hub and a PRE token.
// RQ3 - On endpoint 0 in host mode, bit 6 clear lets hardware retry NAKed transactions, set stops the retry.
// RQ4 - With receive and transmit both enabled, bit 4 set refuses SETUP and keeps IN/OUT, clear also takes SETUP; otherwise bit 4 is ignored.
// RQ5 - Receive (OUT) traffic on an endpoint is taken only while its receive enable, bit 3, is set.
// RQ6 - Transmit (IN) traffic on an endpoint is done only while its transmit enable, bit 2, is set.
// RQ7 - Bit 1 reads one once the endpoint has been stalled and zero when it has not.
// RQ8 - Bit 0 set makes the endpoint run handshake phases, clear suppresses them for isochronous use.
// RQ9 - Bits 31 to 8 and bit 5 are unimplemented, ignore writes and read as zero.
// RQ10 - After reset every implemented bit is zero, so endpoints start disabled, without handshake or stall.
// RQ11 - A token for an endpoint whose needed direction is disabled is ignored and moves no data.
`ifndef USB_EP_CFG_SVH
`define USB_EP_CFG_SVH

// register map, byte addresses on the 8-bit register port
`define OFS_EP_BASE      8'h00
`define OFS_IRQ_STATUS   8'h80
`define OFS_IRQ_CLEAR    8'h84
`define OFS_IRQ_ENABLE   8'h88
`define OFS_HOST_MODE    8'h8C

// endpoint control field positions
`define BIT_LOW_SPEED    7
`define BIT_RETRY_DIS    6
`define BIT_CTRL_DIS     4
`define BIT_RX_EN        3
`define BIT_TX_EN        2
`define BIT_STALLED      1
`define BIT_HSHK_EN      0

// reset values and write masks
`define EP_CTRL_RESET    8'h00
`define EP_CTRL_WMASK    8'hDF
`define IRQ_RESET        4'h0
`define HOST_MODE_RESET  2'h0

// interrupt event positions
`define EV_STALL         0
`define EV_REFUSED       1
`define EV_SETUP_REFUSED 2
`define EV_NAK_RETRY     3

`endif

// [core/usb_ep_pkg.sv]
// types and shared decode for the usb endpoint control block
`include "usb_ep_cfg.svh"

package usb_ep_pkg;

  // token kind as reported by the serial engine
  typedef enum logic [1:0] {pid_out, pid_in, pid_setup} pid_kind_t;

  // outcome of one token, one cycle wide
  typedef struct packed {
    logic valid;
    logic accept;
    logic handshake;
    logic stall;
  } tok_res_t;

  // whether an endpoint control byte admits a given token kind
  function automatic logic ep_admits(input logic [7:0] ctrl, input pid_kind_t kind);
    logic rx;
    logic tx;
    rx = ctrl[`BIT_RX_EN];
    tx = ctrl[`BIT_TX_EN];
    case (kind)
      pid_out:   ep_admits = rx;
      pid_in:    ep_admits = tx;
      pid_setup: ep_admits = rx && !(rx && tx && ctrl[`BIT_CTRL_DIS]);
      default:   ep_admits = 1'b0;
    endcase
  endfunction

endpackage

// [verif/usb_endpoint_control_tb_top.sv]
// self-checking bench for the endpoint control block
`timescale 1ns/1ps
`default_nettype none

module usb_endpoint_control_tb_top
  import usb_ep_pkg::*;
;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [31:0] bus_rdata, rd_val;
  logic        tok_valid, tok_usb, stall_valid, stall_usb, nak_valid, nak_usb, irq;
  logic [3:0]  tok_ep, stall_ep;
  logic [1:0]  low_speed_direct, pre_required, nak_retry;
  pid_kind_t   tok_kind;
  tok_res_t    tok_result;
  int          mismatches = 0;
  int          total_checks = 0;

  always #5 mclk = ~mclk;

  usb_endpoint_control i_dut (.mclk, .arst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .tok_valid, .tok_usb, .tok_ep, .tok_kind, .tok_result, .stall_valid,
    .stall_usb, .stall_ep, .nak_valid, .nak_usb, .low_speed_direct, .pre_required,
    .nak_retry, .irq);
  usb_peer_model i_peer (.mclk, .tok_valid, .tok_usb, .tok_ep, .tok_kind, .stall_valid,
    .stall_usb, .stall_ep, .nak_valid, .nak_usb);

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // bus cycles: one strobe cycle each, read data sampled in the next cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    rd_val = bus_rdata;
  endtask

  // the irq line is registered, so allow a few cycles
  task automatic wait_irq(input logic v);
    for (int n = 0; n < 8 && irq !== v; n++)
      @(posedge mclk) #1;
    total_checks++;
    if (irq !== v)
    begin
      mismatches++;
      $display("[FAIL] %0t irq did not reach %b", $time, v);
      give_verdict();
    end
  endtask

  task automatic t_reset();
    for (int i = 0; i < 36; i++)
      if (i != 33)
      begin
        rd(8'(i * 4));
        chk(rd_val, 32'h0);
      end
  endtask

  // distinct pattern per register catches aliasing; bit 5 always written as one
  task automatic t_regs();
    for (int i = 0; i < 32; i++)
      wr(8'(i * 4), {24'hFFFFFF, 8'(i) ^ 8'hE5});
    for (int i = 0; i < 32; i++)
    begin
      rd(8'(i * 4));
      chk(rd_val, {24'h0, (8'(i) ^ 8'hE5) & 8'hDF});
    end
    wr(8'h90, 32'hFF);
    rd(8'h90);
    chk(rd_val, 32'h0);
  endtask

  // every mix of control-disable, receive, transmit and handshake, all token kinds
  task automatic t_tokens();
    logic [7:0] c;
    logic       a;
    for (int i = 0; i < 16; i++)
    begin
      c = {3'b000, 3'(i >> 1), 1'b0, 1'(i)};
      wr(8'h54, {24'h0, c});
      for (int k = 0; k < 3; k++)
      begin
        i_peer.token(1'b1, 4'h5, pid_kind_t'(k));
        #1;
        a = k == 0 ? c[3] : k == 1 ? c[2] : c[3] && !(c[2] && c[4]);
        chk(32'({tok_result.valid, tok_result.accept}), 32'({1'b1, a}));
        if (a)
          chk(32'(tok_result.handshake), 32'(c[0]));
      end
    end
  endtask

  task automatic t_stall();
    wr(8'h0C, 32'h4);
    i_peer.stall(1'b0, 4'h3);
    rd(8'h0C);
    chk(rd_val, 32'h6);
    i_peer.token(1'b0, 4'h3, pid_in);
    #1;
    chk(32'(tok_result.stall), 32'h1);
    wr(8'h0C, 32'h4);
    rd(8'h0C);
    chk(rd_val, 32'h4);
  endtask

  // host mode off gates ep0 bits; module one direct with retry, module two via hub
  task automatic t_host();
    chk(32'({low_speed_direct, pre_required}), 32'h0);
    wr(8'h8C, 32'h3);
    wr(8'h00, 32'h80);
    wr(8'h40, 32'h40);
    repeat (2) @(posedge mclk);
    #1;
    chk(32'({low_speed_direct, pre_required}), 32'h6);
    i_peer.nak(1'b0);
    #1;
    chk(32'(nak_retry), 32'h1);
    i_peer.nak(1'b1);
    #1;
    chk(32'(nak_retry), 32'h0);
    wr(8'h40, 32'h0);
    i_peer.nak(1'b1);
    #1;
    chk(32'(nak_retry), 32'h2);
    rd(8'h80);
    chk(rd_val, 32'hF);
  endtask

  // reset in mid-run returns registers and outputs to zero
  task automatic t_rereset();
    logic [7:0] addrs [5] = '{8'h00, 8'h54, 8'h80, 8'h88, 8'h8C};
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    chk(32'({low_speed_direct, pre_required, irq}), 32'h0);
    foreach (addrs[j])
    begin
      rd(addrs[j]);
      chk(rd_val, 32'h0);
    end
  endtask

  // refused token raises, mask drops, clear drops
  task automatic t_irq();
    wr(8'h84, 32'hF);
    wr(8'h88, 32'h2);
    wr(8'h60, 32'h0);
    i_peer.token(1'b1, 4'h8, pid_out);
    wait_irq(1'b1);
    rd(8'h80);
    chk(rd_val & 32'h2, 32'h2);
    wr(8'h88, 32'h0);
    wait_irq(1'b0);
    wr(8'h88, 32'h2);
    wait_irq(1'b1);
    wr(8'h84, 32'h2);
    wait_irq(1'b0);
  endtask

  initial
  begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    t_tokens();
    t_stall();
    t_host();
    t_irq();
    t_rereset();
    give_verdict();
  end
endmodule

`default_nettype wire

// [verif/usb_ep_props.sv]
// port-level checks for the endpoint control block
`timescale 1ns/1ps
`default_nettype none

module usb_ep_props
  import usb_ep_pkg::*;
(
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic [7:0]  bus_addr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic        tok_valid,
  input wire tok_res_t    tok_result,
  input wire logic        nak_valid,
  input wire logic        nak_usb,
  input wire logic [1:0]  low_speed_direct,
  input wire logic [1:0]  pre_required,
  input wire logic [1:0]  nak_retry,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // read data appear only after a read, and never above the byte
  rd_quiet_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("read data outside read cycle");
  hi_zero_a: assert property (bus_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  bit5_zero_a: assert property ($past(bus_rd && !bus_addr[7]) |-> !bus_rdata[5])
    else $error("endpoint bit 5 read as one");
  // one result per token, none without one
  res_pulse_a: assert property (tok_valid |=> tok_result.valid)
    else $error("token without result");
  res_quiet_a: assert property (!tok_valid |=> !tok_result.valid && !tok_result.accept)
    else $error("result without token");
  stall_acc_a: assert property (tok_result.stall |-> tok_result.accept)
    else $error("stall flag on refused token");
  // direct and hub paths exclude each other
  ls_pre_a: assert property ((low_speed_direct & pre_required) == 2'h0)
    else $error("direct and hub both selected");
  nak_one_a: assert property (nak_retry[0] |-> $past(nak_valid && !nak_usb))
    else $error("retry on module one without nak");
  nak_two_a: assert property (nak_retry[1] |-> $past(nak_valid && nak_usb))
    else $error("retry on module two without nak");

  cover property (tok_result.accept);
  cover property (nak_retry[0]);
  cover property ($rose(irq));
endmodule

bind usb_endpoint_control usb_ep_props i_props (.mclk, .arst_n, .bus_addr, .bus_rd,
  .bus_rdata, .tok_valid, .tok_result, .nak_valid, .nak_usb, .low_speed_direct,
  .pre_required, .nak_retry, .irq);

`default_nettype wire

// [verif/usb_peer_model.sv]
// far-side serial engine: tokens, stall reports and naks
`timescale 1ns/1ps
`default_nettype none

module usb_peer_model
  import usb_ep_pkg::*;
(
  input  wire logic       mclk,
  output logic            tok_valid,
  output logic            tok_usb,
  output logic      [3:0] tok_ep,
  output pid_kind_t       tok_kind,
  output logic            stall_valid,
  output logic            stall_usb,
  output logic      [3:0] stall_ep,
  output logic            nak_valid,
  output logic            nak_usb
);
  initial
  begin
    {tok_valid, tok_usb, tok_ep, stall_valid, stall_usb, stall_ep} = '0;
    {nak_valid, nak_usb} = '0;
    tok_kind = pid_out;
  end

  // usb and endpoint qualifiers flip once idle, stall_usb excepted, so stale values are never mistaken for live ones
  task automatic token(input logic u, input logic [3:0] e, input pid_kind_t k);
    @(posedge mclk);
    tok_valid <= 1'b1;
    tok_usb   <= u;
    tok_ep    <= e;
    tok_kind  <= k;
    @(posedge mclk);
    tok_valid <= 1'b0;
    tok_usb   <= ~u;
    tok_ep    <= ~e;
  endtask

  task automatic stall(input logic u, input logic [3:0] e);
    @(posedge mclk);
    stall_valid <= 1'b1;
    stall_usb   <= u;
    stall_ep    <= e;
    @(posedge mclk);
    stall_valid <= 1'b0;
    stall_ep    <= ~e;
  endtask

  task automatic nak(input logic u);
    @(posedge mclk);
    nak_valid <= 1'b1;
    nak_usb   <= u;
    @(posedge mclk);
    nak_valid <= 1'b0;
    nak_usb   <= ~u;
  endtask
endmodule

`default_nettype wire
